// [core/rpaa_pkg.sv]
// rpaa_pkg: constants, block builders and aes-128 helpers shared by both link ends.
// assumes one 250 MHz clock and the byte order of the on-air telegram (first byte at the msb).
package rpaa_pkg;
    localparam int ADDR_W = 48;
    localparam int KEY_W = 128;
    localparam int SIG_W = 32;
    localparam int HASH_W = 24;
    localparam int PAD_W = 104;
    localparam int CLK_MHZ = 250;
    localparam logic [1:0] RPA_MODE = 2'b01;
    localparam logic [3:0] AES_LAST = 4'ha;
    localparam logic [7:0] A0_FLAG = 8'h01;
    localparam logic [7:0] B0_FLAG = 8'h49;
    localparam logic [7:0] TYPE_MFR = 8'hff;
    localparam logic [7:0] PAY_LEN_BASE = 8'h0c;
    localparam logic [15:0] IN_LEN_BASE = 16'h0009;
    localparam logic [15:0] CTR_TAIL = 16'h0000;
    // manufacturer code carried in the payload; value is arbitrary
    localparam logic [15:0] MFR_ID = 16'h0a5c;
    localparam int ERR_NOID = 0;
    localparam int ERR_REPLAY = 1;
    localparam int ERR_SIG = 2;

    function automatic logic [2:0] opt_bytes(input logic [1:0] code);
        return (code == 2'h3) ? 3'h4 : {1'b0, code};
    endfunction

    function automatic logic [31:0] le32(input logic [31:0] v);
        return {v[7:0], v[15:8], v[23:16], v[31:24]};
    endfunction

    function automatic logic [47:0] le48(input logic [47:0] v);
        return {v[7:0], v[15:8], v[23:16], v[31:24], v[39:32], v[47:40]};
    endfunction

    function automatic logic [127:0] blk_ctr(input logic [7:0] flag, input logic [47:0] addr,
                                             input logic [31:0] seq);
        return {flag, le48(addr), le32(seq), 24'h000000, CTR_TAIL};
    endfunction

    function automatic logic [127:0] blk_b1(input logic [31:0] seq, input logic [7:0] status,
                                            input logic [31:0] opt, input logic [1:0] code);
        logic [2:0] n;
        logic [103:0] data;
        logic [103:0] keep;
        n = opt_bytes(code);
        data = {PAY_LEN_BASE + {5'h00, n}, TYPE_MFR, MFR_ID[7:0], MFR_ID[15:8], le32(seq), status, le32(opt)};
        keep = {PAD_W{1'b1}} << (8 * (4 - int'(n)));
        return {IN_LEN_BASE + {13'h0000, n}, data & keep, 8'h00};
    endfunction

    function automatic logic [7:0] xt(input logic [7:0] a);
        return {a[6:0], 1'b0} ^ (a[7] ? 8'h1b : 8'h00);
    endfunction

    function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p;
        logic [7:0] x;
        p = 8'h00;
        x = a;
        for (int i = 0; i < 8; i++) begin
            if (b[i]) begin
                p = p ^ x;
            end
            x = xt(x);
        end
        return p;
    endfunction

    // s-box as inverse (x^254) plus affine map: no table, at the price of logic depth
    function automatic logic [7:0] sbox(input logic [7:0] x);
        logic [7:0] p;
        logic [7:0] b;
        p = x;
        b = 8'h01;
        for (int i = 0; i < 7; i++) begin
            p = gf_mul(p, p);
            b = gf_mul(b, p);
        end
        return b ^ {b[6:0], b[7]} ^ {b[5:0], b[7:6]} ^ {b[4:0], b[7:5]} ^ {b[3:0], b[7:4]} ^ 8'h63;
    endfunction

    function automatic logic [7:0] rcon(input logic [3:0] r);
        logic [7:0] c;
        c = 8'h01;
        for (int i = 1; i < 10; i++) begin
            if (i < int'(r)) begin
                c = xt(c);
            end
        end
        return c;
    endfunction

    function automatic logic [127:0] key_next(input logic [127:0] rk, input logic [3:0] r);
        logic [31:0] w3;
        logic [31:0] t;
        logic [31:0] n0;
        logic [31:0] n1;
        logic [31:0] n2;
        w3 = rk[31:0];
        t = {sbox(w3[23:16]), sbox(w3[15:8]), sbox(w3[7:0]), sbox(w3[31:24])} ^ {rcon(r), 24'h000000};
        n0 = rk[127:96] ^ t;
        n1 = rk[95:64] ^ n0;
        n2 = rk[63:32] ^ n1;
        return {n0, n1, n2, w3 ^ n2};
    endfunction

    function automatic logic [127:0] aes_round(input logic [127:0] st, input logic [127:0] rk,
                                               input logic last);
        logic [7:0] s [16];
        logic [7:0] t [16];
        logic [127:0] o;
        for (int i = 0; i < 16; i++) begin
            s[i] = sbox(st[127 - 8 * i -: 8]);
        end
        for (int c = 0; c < 4; c++) begin
            for (int r = 0; r < 4; r++) begin
                t[4 * c + r] = s[4 * ((c + r) % 4) + r];
            end
        end
        for (int c = 0; c < 4; c++) begin
            for (int r = 0; r < 4; r++) begin
                o[127 - 8 * (4 * c + r) -: 8] = last ? t[4 * c + r] :
                    xt(t[4 * c + r]) ^ xt(t[4 * c + (r + 1) % 4]) ^ t[4 * c + (r + 1) % 4] ^
                    t[4 * c + (r + 2) % 4] ^ t[4 * c + (r + 3) % 4];
            end
        end
        return o ^ rk;
    endfunction
endpackage

// [core/rpaa_link_if.sv]
// rpaa_link_if: one telegram per valid/ready handshake from transmitter to receiver.
// assumes both ends run on the same mclk; the testbench joins them.
`timescale 1ns/1ps
interface rpaa_link_if;
    logic valid;
    logic ready;
    logic [47:0] addr;
    logic [31:0] seq;
    logic [7:0] status;
    logic [31:0] opt;
    logic [1:0] opt_size;
    logic [31:0] sig;
    modport tx (output valid, addr, seq, status, opt, opt_size, sig, input ready);
    modport rx (input valid, addr, seq, status, opt, opt_size, sig, output ready);
endinterface

// [core/rpaa_tx.sv]
// rpaa_tx: transmitter end; numbers and signs each data telegram and offers it on the link.
// assumes the user raises send or resend for one cycle while busy is low.
`timescale 1ns/1ps
module rpaa_tx (
    input wire logic mclk,
    input wire logic reset,
    rpaa_link_if.tx link,
    input wire logic send,
    input wire logic resend,
    input wire logic [47:0] src_addr,
    input wire logic [7:0] status,
    input wire logic [31:0] opt_data,
    input wire logic [1:0] opt_size,
    input wire logic [127:0] sec_key,
    output logic busy,
    output logic [31:0] next_seq
);
    typedef enum logic [2:0] {IDLE, X1, X2, S0, SEND} rpaa_txst_t;
    rpaa_txst_t state_q;
    logic [127:0] st_q, rk_q, kn, go_pt_q, key_q, x2_q;
    logic [3:0] rnd_q;
    logic run_q, done_q, go_q, valid_q, have_q;
    logic [31:0] ctr_q, seq_q, sig_q, opt_q;
    logic [47:0] addr_q;
    logic [7:0] stat_q;
    logic [1:0] code_q;

    assign kn = rpaa_pkg::key_next(rk_q, rnd_q);
    assign busy = (state_q != IDLE);
    assign next_seq = ctr_q;
    assign link.valid = valid_q;
    assign link.addr = addr_q;
    assign link.seq = seq_q;
    assign link.status = stat_q;
    assign link.opt = opt_q;
    assign link.opt_size = code_q;
    assign link.sig = sig_q;

    // iterative aes-128: one round per clock, result in st_q when done_q
    always_ff @(posedge mclk) begin
        if (reset) begin
            run_q <= 1'b0;
            done_q <= 1'b0;
            rnd_q <= 4'h0;
            st_q <= 128'h0;
            rk_q <= 128'h0;
        end else begin
            done_q <= run_q && (rnd_q == rpaa_pkg::AES_LAST);
            if (go_q) begin
                st_q <= go_pt_q ^ key_q;
                rk_q <= key_q;
                rnd_q <= 4'h1;
                run_q <= 1'b1;
            end else if (run_q) begin
                rk_q <= kn;
                st_q <= rpaa_pkg::aes_round(st_q, kn, rnd_q == rpaa_pkg::AES_LAST);
                rnd_q <= rnd_q + 4'h1;
                if (rnd_q == rpaa_pkg::AES_LAST) begin
                    run_q <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_q <= IDLE;
            go_q <= 1'b0;
            go_pt_q <= 128'h0;
            key_q <= 128'h0;
            x2_q <= 128'h0;
            valid_q <= 1'b0;
            have_q <= 1'b0;
            ctr_q <= 32'h0;
            seq_q <= 32'h0;
            sig_q <= 32'h0;
            opt_q <= 32'h0;
            addr_q <= 48'h0;
            stat_q <= 8'h00;
            code_q <= 2'h0;
        end else begin
            go_q <= 1'b0;
            unique case (state_q)
                IDLE: begin
                    if (send) begin
                        addr_q <= src_addr;
                        stat_q <= status;
                        opt_q <= opt_data;
                        code_q <= opt_size;
                        key_q <= sec_key;
                        seq_q <= ctr_q;
                        ctr_q <= ctr_q + 32'h1;
                        go_pt_q <= rpaa_pkg::blk_ctr(rpaa_pkg::B0_FLAG, src_addr, ctr_q);
                        go_q <= 1'b1;
                        state_q <= X1;
                    end else if (resend && have_q) begin
                        valid_q <= 1'b1;
                        state_q <= SEND;
                    end
                end
                X1: begin
                    if (done_q) begin
                        go_pt_q <= st_q ^ rpaa_pkg::blk_b1(seq_q, stat_q, opt_q, code_q);
                        go_q <= 1'b1;
                        state_q <= X2;
                    end
                end
                X2: begin
                    if (done_q) begin
                        x2_q <= st_q;
                        go_pt_q <= rpaa_pkg::blk_ctr(rpaa_pkg::A0_FLAG, addr_q, seq_q);
                        go_q <= 1'b1;
                        state_q <= S0;
                    end
                end
                S0: begin
                    if (done_q) begin
                        sig_q <= x2_q[127:96] ^ st_q[127:96];
                        valid_q <= 1'b1;
                        have_q <= 1'b1;
                        state_q <= SEND;
                    end
                end
                SEND: begin
                    if (link.ready) begin
                        valid_q <= 1'b0;
                        state_q <= IDLE;
                    end
                end
            endcase
        end
    end
endmodule

// [core/rpaa_rx.sv]
// rpaa_rx: receiver end; resolves private addresses, checks signatures, refuses replays.
// assumes the key stores (irk, auth_key, static_addr) are held steady by the user.
// Operation
// - prand upper 24 bits, hash lower
// - resolve only when prand top bits 01
// - pad prand with 104 zero bits
// - aes-128 of padded prand with irk
// - low 24 result bits equal hash
// - try every stored irk, match names sender
// - two-byte length field
// - signature is exactly four bytes
// - sender address enters little-endian
// - length 9, 10, 11, 13 by option
// - payload 9 bytes, never over 13
// - payload fields in telegram order
// - sender counter from zero, copies repeat
// - accept only counters above highest seen
// - counter in bytes 4 to 7, little-endian
// - shared 128-bit secret key
// - inputs from telegram, key from store
// - nonce: address, counter, zero padding
// - a0 flag 01, b0 flag 49
// - b1: length, data, zero padding
// - three encryptions, two xors, four bytes
`timescale 1ns/1ps
module rpaa_rx #(
    parameter int NKEY = 4
) (
    input wire logic mclk,
    input wire logic reset,
    rpaa_link_if.rx link,
    input wire logic [NKEY-1:0][127:0] irk,
    input wire logic [NKEY-1:0][127:0] auth_key,
    input wire logic [NKEY-1:0][47:0] static_addr,
    output logic busy,
    output logic rep_valid,
    output logic rep_ok,
    output logic [2:0] rep_err,
    output logic [((NKEY > 1) ? $clog2(NKEY) : 1)-1:0] rep_slot,
    output logic [47:0] rep_addr,
    output logic [31:0] rep_seq,
    output logic [7:0] rep_status,
    output logic [31:0] rep_opt,
    output logic [1:0] rep_opt_size
);
    localparam int IW = (NKEY > 1) ? $clog2(NKEY) : 1;

    if (NKEY < 1 || NKEY > 256) begin : g_chk
        $error("rpaa_rx: NKEY must be 1 to 256");
    end

    typedef enum logic [2:0] {IDLE, RES, X1, X2, S0} rpaa_rxst_t;
    rpaa_rxst_t state_q;
    logic [127:0] st_q, rk_q, kn, go_pt_q, key_q, x2_q;
    logic [3:0] rnd_q;
    logic run_q, done_q, go_q;
    logic [47:0] addr_q;
    logic [31:0] seq_q, opt_q, sig_q;
    logic [7:0] stat_q;
    logic [1:0] code_q;
    logic [IW-1:0] k_q, st_idx;
    logic st_hit, sig_ok, fresh, accept;
    logic [NKEY-1:0][31:0] last_q;
    logic [NKEY-1:0] seen_q;
    logic [23:0] prand_in;

    assign kn = rpaa_pkg::key_next(rk_q, rnd_q);
    // prand from upper half of address
    assign prand_in = link.addr[47:24];
    assign link.ready = (state_q == IDLE);
    assign busy = (state_q != IDLE);
    assign sig_ok = ((x2_q[127:96] ^ st_q[127:96]) == sig_q);
    assign fresh = !seen_q[k_q] || (seq_q > last_q[k_q]);
    assign accept = (state_q == S0) && done_q && sig_ok && fresh;

    // static address lookup for telegrams that are not private resolvable
    always_comb begin
        st_hit = 1'b0;
        st_idx = '0;
        for (int i = NKEY - 1; i >= 0; i--) begin
            if (static_addr[i] == link.addr) begin
                st_hit = 1'b1;
                st_idx = IW'(i);
            end
        end
    end

    // iterative aes-128: one round per clock, result in st_q when done_q
    always_ff @(posedge mclk) begin
        if (reset) begin
            run_q <= 1'b0;
            done_q <= 1'b0;
            rnd_q <= 4'h0;
            st_q <= 128'h0;
            rk_q <= 128'h0;
        end else begin
            done_q <= run_q && (rnd_q == rpaa_pkg::AES_LAST);
            if (go_q) begin
                st_q <= go_pt_q ^ key_q;
                rk_q <= key_q;
                rnd_q <= 4'h1;
                run_q <= 1'b1;
            end else if (run_q) begin
                rk_q <= kn;
                st_q <= rpaa_pkg::aes_round(st_q, kn, rnd_q == rpaa_pkg::AES_LAST);
                rnd_q <= rnd_q + 4'h1;
                if (rnd_q == rpaa_pkg::AES_LAST) begin
                    run_q <= 1'b0;
                end
            end
        end
    end

    // per-sender highest accepted counter; only authenticated telegrams move it
    always_ff @(posedge mclk) begin
        if (reset) begin
            last_q <= '0;
            seen_q <= '0;
        end else if (accept) begin
            last_q[k_q] <= seq_q;
            seen_q[k_q] <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_q <= IDLE;
            go_q <= 1'b0;
            go_pt_q <= 128'h0;
            key_q <= 128'h0;
            x2_q <= 128'h0;
            addr_q <= 48'h0;
            seq_q <= 32'h0;
            opt_q <= 32'h0;
            sig_q <= 32'h0;
            stat_q <= 8'h00;
            code_q <= 2'h0;
            k_q <= '0;
            rep_valid <= 1'b0;
            rep_ok <= 1'b0;
            rep_err <= 3'h0;
            rep_slot <= '0;
            rep_addr <= 48'h0;
            rep_seq <= 32'h0;
            rep_status <= 8'h00;
            rep_opt <= 32'h0;
            rep_opt_size <= 2'h0;
        end else begin
            go_q <= 1'b0;
            rep_valid <= 1'b0;
            unique case (state_q)
                IDLE: begin
                    if (link.valid) begin
                        // all inputs but the key from the telegram
                        addr_q <= link.addr;
                        seq_q <= link.seq;
                        stat_q <= link.status;
                        opt_q <= link.opt;
                        code_q <= link.opt_size;
                        sig_q <= link.sig;
                        if (prand_in[23:22] == rpaa_pkg::RPA_MODE) begin
                            k_q <= '0;
                            key_q <= irk[0];
                            go_pt_q <= {{rpaa_pkg::PAD_W{1'b0}}, prand_in};
                            go_q <= 1'b1;
                            state_q <= RES;
                        end else if (st_hit) begin
                            k_q <= st_idx;
                            key_q <= auth_key[st_idx];
                            go_pt_q <= rpaa_pkg::blk_ctr(rpaa_pkg::B0_FLAG, link.addr, link.seq);
                            go_q <= 1'b1;
                            state_q <= X1;
                        end else begin
                            rep_valid <= 1'b1;
                            rep_ok <= 1'b0;
                            rep_err <= 3'h1 << rpaa_pkg::ERR_NOID;
                            rep_slot <= '0;
                            rep_addr <= link.addr;
                            rep_seq <= link.seq;
                            rep_status <= link.status;
                            rep_opt <= link.opt;
                            rep_opt_size <= link.opt_size;
                        end
                    end
                end
                RES: begin
                    if (done_q) begin
                        if (st_q[rpaa_pkg::HASH_W-1:0] == addr_q[rpaa_pkg::HASH_W-1:0]) begin
                            key_q <= auth_key[k_q];
                            go_pt_q <= rpaa_pkg::blk_ctr(rpaa_pkg::B0_FLAG, addr_q, seq_q);
                            go_q <= 1'b1;
                            state_q <= X1;
                        end else if (int'(k_q) == NKEY - 1) begin
                            rep_valid <= 1'b1;
                            rep_ok <= 1'b0;
                            rep_err <= 3'h1 << rpaa_pkg::ERR_NOID;
                            rep_slot <= '0;
                            rep_addr <= addr_q;
                            rep_seq <= seq_q;
                            rep_status <= stat_q;
                            rep_opt <= opt_q;
                            rep_opt_size <= code_q;
                            state_q <= IDLE;
                        end else begin
                            k_q <= k_q + IW'(1);
                            key_q <= irk[k_q + IW'(1)];
                            go_q <= 1'b1;
                        end
                    end
                end
                X1: begin
                    if (done_q) begin
                        go_pt_q <= st_q ^ rpaa_pkg::blk_b1(seq_q, stat_q, opt_q, code_q);
                        go_q <= 1'b1;
                        state_q <= X2;
                    end
                end
                X2: begin
                    if (done_q) begin
                        x2_q <= st_q;
                        go_pt_q <= rpaa_pkg::blk_ctr(rpaa_pkg::A0_FLAG, addr_q, seq_q);
                        go_q <= 1'b1;
                        state_q <= S0;
                    end
                end
                S0: begin
                    if (done_q) begin
                        rep_valid <= 1'b1;
                        rep_ok <= sig_ok && fresh;
                        rep_err <= ({2'h0, !sig_ok} << rpaa_pkg::ERR_SIG) |
                                   ({2'h0, !fresh} << rpaa_pkg::ERR_REPLAY);
                        rep_slot <= k_q;
                        rep_addr <= addr_q;
                        rep_seq <= seq_q;
                        rep_status <= stat_q;
                        rep_opt <= opt_q;
                        rep_opt_size <= code_q;
                        state_q <= IDLE;
                    end
                end
            endcase
        end
    end
endmodule

// [tb/rpaa_link_chk.sv]
// rpaa_link_chk: concurrent checks on the telegram link between the two ends.
// assumes the testbench instantiates it beside the link interface, on mclk.
`timescale 1ns/1ps
module rpaa_link_chk (
    input wire logic mclk,
    input wire logic reset,
    input wire logic valid,
    input wire logic ready,
    input wire logic [47:0] addr,
    input wire logic [31:0] seq,
    input wire logic [7:0] status,
    input wire logic [31:0] opt,
    input wire logic [1:0] opt_size,
    input wire logic [31:0] sig
);
    logic have_q;
    logic [31:0] seq_q;
    logic [31:0] sig_q;
    always_ff @(posedge mclk) begin
        if (reset) begin
            have_q <= 1'b0;
            seq_q <= 32'h0;
            sig_q <= 32'h0;
        end else if (valid && ready) begin
            have_q <= 1'b1;
            seq_q <= seq;
            sig_q <= sig;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    sequence take_s;
        valid && ready;
    endsequence
    sequence release_s;
        // a private address always keeps the receiver busy; an unknown public one is judged at once
        !valid && (!ready || addr[47:46] != rpaa_pkg::RPA_MODE);
    endsequence
    take_release_a: assert property (take_s |=> release_s) else $error("link not released after take");
    data_hold_a: assert property (valid && !ready |=>
        valid && $stable({addr, seq, status, opt, opt_size, sig})) else $error("telegram changed while offered");
    ready_back_a: assert property ($fell(ready) |-> ##[1:90] ready) else $error("receiver stuck busy");
    wait_take_a: assert property ($rose(valid) |-> ##[0:90] take_s) else $error("telegram never taken");
    // reset value is checked with reset itself as the cause
    reset_idle_a: assert property (disable iff (1'b0) reset |=>
        !valid && ready && seq == 32'h0 && addr == 48'h0) else $error("link not idle after reset");
    first_seq_a: assert property ($rose(valid) && !have_q |-> seq == 32'h0)
        else $error("first counter not zero");
    seq_step_a: assert property ($rose(valid) && have_q |-> seq == seq_q || seq == seq_q + 32'h1)
        else $error("counter skipped");
    resend_same_a: assert property ($rose(valid) && have_q && seq == seq_q |-> sig == sig_q)
        else $error("repeated copy has other signature");
endmodule

// [tb/test_rpa_resolve_and_telegram_auth.sv]
// test_rpa_resolve_and_telegram_auth: transmitter and receiver joined back to back.
// assumes one 250 MHz mclk; key stores held steady from time zero.
`timescale 1ns/1ps
module test_rpa_resolve_and_telegram_auth;
    localparam logic [127:0] KEY = 128'h3dda31ad44767ae3ce56dce2b3ce2abb;
    localparam logic [47:0] RPA = 48'h493970e51944;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic send = 1'b0;
    logic resend = 1'b0;
    logic [47:0] src_addr = 48'h0;
    logic [1:0] opt_size = 2'h0;
    logic [127:0] sec_key = 128'h0;
    logic tx_busy;
    logic rx_busy;
    logic rep_valid;
    logic rep_ok;
    logic [2:0] rep_err;
    logic [1:0] rep_slot;
    logic [47:0] rep_addr;
    logic [31:0] rep_seq;
    logic [7:0] rep_status;
    logic [31:0] rep_opt;
    logic [1:0] rep_opt_size;
    logic [31:0] next_seq;
    logic [3:0][127:0] irk = {128'h5a5a0f0f, 128'h77, 128'hbe759a027a4870fd242794f4c45220fb, 128'h1234};
    logic [3:0][127:0] auth_key = {~KEY, KEY, KEY, ~KEY};
    logic [3:0][47:0] static_addr = {48'h1, 48'he215000019b8, 48'h2, 48'h3};
    int error_cnt = 0;
    int check_count = 0;
    always #2 mclk = ~mclk;
    rpaa_link_if link();
    rpaa_tx i_rpaa_tx (.mclk(mclk), .reset(reset), .link(link), .send(send), .resend(resend), .src_addr(src_addr),
        .status(8'h11), .opt_data(32'h44332211), .opt_size(opt_size), .sec_key(sec_key), .busy(tx_busy),
        .next_seq(next_seq));
    rpaa_rx #(.NKEY(4)) i_rpaa_rx (.mclk(mclk), .reset(reset), .link(link), .irk(irk), .auth_key(auth_key),
        .static_addr(static_addr), .busy(rx_busy), .rep_valid(rep_valid), .rep_ok(rep_ok), .rep_err(rep_err),
        .rep_slot(rep_slot), .rep_addr(rep_addr), .rep_seq(rep_seq), .rep_status(rep_status), .rep_opt(rep_opt),
        .rep_opt_size(rep_opt_size));
    rpaa_link_chk i_rpaa_link_chk (.mclk(mclk), .reset(reset), .valid(link.valid), .ready(link.ready),
        .addr(link.addr), .seq(link.seq), .status(link.status), .opt(link.opt), .opt_size(link.opt_size),
        .sig(link.sig));

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one telegram: send or resend, then judge the receiver's report and its latency
    task automatic tg(input logic [47:0] a, input logic [1:0] osz, input logic [127:0] k, input logic rs,
                      input logic [3:0] verdict, input logic [1:0] slot, input int lat, input logic [31:0] sq);
        int n;
        @(negedge mclk);
        src_addr = a;
        opt_size = osz;
        sec_key = k;
        send = !rs;
        resend = rs;
        @(negedge mclk);
        send = 1'b0;
        resend = 1'b0;
        n = 0;
        while (!(link.valid && link.ready) && n < 200) begin
            @(negedge mclk);
            n++;
        end
        chk(64'(n < 200), 64'h1);
        chk({link.addr, link.opt_size}, {a, osz});
        chk(link.seq, sq);
        chk(next_seq, sq + 32'h1);
        chk({tx_busy, rx_busy}, 2'h2);
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (!rep_valid && n < 200);
        // n counts falling edges after the take edge, so the report edge is n - 1 edges later
        chk(64'(n - 1), 64'(lat));
        chk({rep_ok, rep_err}, verdict);
        chk({rep_addr, rep_opt_size}, {a, osz});
        chk(rep_seq, sq);
        chk({rep_status, rep_opt}, {8'h11, 32'h44332211});
        chk({tx_busy, rx_busy}, 2'h0);
        if (!verdict[1]) begin
            chk(rep_slot, slot);
        end
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        #40000;
        error_cnt++;
        conclude();
    end

    initial begin
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        reset = 1'b0;
        tg(RPA, 2'h0, KEY, 1'b0, 4'h8, 2'h1, 60, 32'h0);
        tg(RPA, 2'h0, KEY, 1'b1, 4'h2, 2'h1, 60, 32'h0);
        for (int i = 1; i < 4; i++) begin
            tg(RPA, 2'(i), KEY, 1'b0, 4'h8, 2'h1, 60, 32'(i));
        end
        tg(RPA, 2'h0, ~KEY, 1'b0, 4'h4, 2'h1, 60, 32'h4);
        tg(RPA, 2'h0, KEY, 1'b0, 4'h8, 2'h1, 60, 32'h5);
        tg(48'he215000019b8, 2'h0, KEY, 1'b0, 4'h8, 2'h2, 36, 32'h6);
        tg(48'h493970e51945, 2'h0, KEY, 1'b0, 4'h1, 2'h0, 48, 32'h7);
        // an unknown public address is judged on the take edge itself
        tg(48'hc93970e51944, 2'h0, KEY, 1'b0, 4'h1, 2'h0, 0, 32'h8);
        conclude();
    end
endmodule
